// ### logic/bus_cycle_trigger_qualifier.sv
// qualifier matching of target bus cycles against programmed actions
//
// What this block does
// - each action owns address and data value pairs
// - address pair: single, either, inside, outside
// - data pair uses same four interpretations
// - single-value interpretation unless reprogrammed
// - 16-bit address mask, 8-bit data/probe masks
// - mask ANDs both input and stored value
// - value without explicit mask gets all ones
// - ignored comparison has mask zero, always matches
// - new action: all ignored, all cycles, fires once its enable bit is set; actions 2 and 3 only in address-only mode
// - jump action carries destination state zero-three
// - address-only mode: data never influences firing
// - eight cycle-type settings, none never fires
// - cycle condition restricts address and data jointly
// - ignored cycle condition accepts all cycles
// - probe inputs compared with value under mask
// - action fires only when all conditions hold
// - address+data mode: two actions, address-only four
module bus_cycle_trigger_qualifier (
    // clock and reset
    input  wire logic                         mclk_in,
    input  wire logic                         nrst_in,
    // register port
    input  wire logic [7:0]                   reg_addr_in,
    input  wire logic [15:0]                  reg_wdata_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    output logic      [15:0]                  reg_rdata_out,
    // target bus and probes, asynchronous
    input  wire qual_pkg::bus_obs_s           bus_in,
    // results toward the sequencer
    output logic      [qual_pkg::NUM_ACT-1:0] fire_out,
    output logic                              jump_out,
    output logic      [1:0]                   jump_state_out,
    // interrupt
    output logic                              irq_out
);

    // programmed actions, state mode and interrupt registers
    qual_pkg::act_cfg_s               act_q [qual_pkg::NUM_ACT];
    logic                             addr_only_q;   // state runs address-only
    logic [qual_pkg::NUM_ACT-1:0]     status_q;      // sticky fire flags
    logic [qual_pkg::NUM_ACT-1:0]     irq_mask_q;    // interrupt enables
    logic [qual_pkg::NUM_ACT-1:0]     fire_q;        // last cycle result
    logic [qual_pkg::NUM_ACT-1:0]     fire_d;
    logic                             jump_q;
    logic [1:0]                       jump_state_q;
    logic                             irq_q;
    logic [15:0]                      rdata_q;
    // synchroniser and edge detect for the target bus
    qual_pkg::bus_obs_s               sync1_q;
    qual_pkg::bus_obs_s               sync2_q;
    logic                             strobe_prev_q;
    logic                             bus_evt;       // one observed bus cycle
    // decoded access
    logic [1:0]                       acc_act;
    logic [3:0]                       acc_fld;
    logic                             acc_is_act;
    logic [qual_pkg::NUM_ACT-1:0]     qual;          // per action match

    // compare one masked value pair under an interpretation
    function automatic logic pair_match(input logic [15:0] x, input logic [15:0] v1,
                                        input logic [15:0] v2, input logic [15:0] mask,
                                        input qual_pkg::range_e mode);
        logic [15:0] mx;
        logic [15:0] m1;
        logic [15:0] m2;
        logic        res;
        mx = x & mask;
        m1 = v1 & mask;
        m2 = v2 & mask;
        unique case (mode)
            qual_pkg::RANGE_SINGLE:  res = (mx == m1);
            qual_pkg::RANGE_EITHER:  res = (mx == m1) || (mx == m2);
            qual_pkg::RANGE_INSIDE:  res = (mx >= m1) && (mx <= m2);
            qual_pkg::RANGE_OUTSIDE: res = (mx < m1) || (mx > m2);
        endcase
        // an ignored qualifier matches any value, whatever its interpretation
        if (mask == qual_pkg::MASK16_IGNORE) res = 1'b1;
        return res;
    endfunction

    // does the observed cycle kind satisfy a selection
    function automatic logic cyc_match(input qual_pkg::cyc_sel_e sel, input logic f,
                                       input logic r, input logic w);
        logic res;
        unique case (sel)
            qual_pkg::CYC_ALL:         res = 1'b1;
            qual_pkg::CYC_NONE:        res = 1'b0;
            qual_pkg::CYC_READ:        res = r;
            qual_pkg::CYC_WRITE:       res = w;
            qual_pkg::CYC_READ_WRITE:  res = r | w;
            qual_pkg::CYC_FETCH:       res = f;
            qual_pkg::CYC_FETCH_READ:  res = f | r;
            qual_pkg::CYC_FETCH_WRITE: res = f | w;
        endcase
        return res;
    endfunction

    // address split into action slot and field
    assign acc_act    = reg_addr_in[5:4];
    assign acc_fld    = reg_addr_in[3:0];
    assign acc_is_act = (reg_addr_in[7:6] == 2'b00);

    // two-flop synchroniser of the whole bus sample
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_q       <= '0;
            sync2_q       <= '0;
            strobe_prev_q <= 1'b0;
        end else begin
            sync1_q       <= bus_in;
            sync2_q       <= sync1_q;
            strobe_prev_q <= sync2_q.strobe;
        end
    end

    // a bus cycle is the rising edge of the synchronised strobe
    assign bus_evt = sync2_q.strobe & ~strobe_prev_q;

    // per action qualification, all conditions ANDed
    genvar gi;
    generate
        for (gi = 0; gi < qual_pkg::NUM_ACT; gi++) begin : g_act
            logic a_ok;
            logic d_ok;
            logic p_ok;
            logic c_ok;
            logic slot_ok;
            assign a_ok = pair_match(sync2_q.addr, act_q[gi].addr_v1,
                                     act_q[gi].addr_v2, act_q[gi].addr_mask,
                                     act_q[gi].arange);
            assign d_ok = addr_only_q ||
                          pair_match({8'h00, sync2_q.data}, {8'h00, act_q[gi].data_v1},
                                     {8'h00, act_q[gi].data_v2},
                                     {8'h00, act_q[gi].data_mask},
                                     act_q[gi].drange);
            assign p_ok = ((sync2_q.probe ^ act_q[gi].probe_v)
                           & act_q[gi].probe_mask) == 8'h00;
            assign c_ok = cyc_match(act_q[gi].cyc_sel, sync2_q.instruction_fetch_cycle,
                                    sync2_q.memory_read_cycle,
                                    sync2_q.memory_write_cycle);
            // only two slots exist in address plus data mode
            assign slot_ok = addr_only_q || (gi < qual_pkg::AD_MAX_ACT);
            assign qual[gi] = act_q[gi].enable & slot_ok & a_ok & d_ok & p_ok
                              & c_ok;
        end
    endgenerate

    // result for the current bus cycle only
    assign fire_d = bus_evt ? qual : '0;

    // action programming; a value write also restores its mask to all ones
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < qual_pkg::NUM_ACT; i++) begin
                act_q[i]            <= '0;
                act_q[i].addr_mask  <= qual_pkg::MASK16_IGNORE;
                act_q[i].data_mask  <= qual_pkg::MASK8_IGNORE;
                act_q[i].probe_mask <= qual_pkg::MASK8_IGNORE;
                act_q[i].cyc_sel    <= qual_pkg::CYC_ALL;
            end
        end else if (reg_wr_in && acc_is_act) begin
            unique case (acc_fld)
                qual_pkg::F_ADDR_V1: begin
                    act_q[acc_act].addr_v1   <= reg_wdata_in;
                    act_q[acc_act].addr_mask <= qual_pkg::MASK16_ALL;
                end
                qual_pkg::F_ADDR_V2: begin
                    act_q[acc_act].addr_v2   <= reg_wdata_in;
                    act_q[acc_act].addr_mask <= qual_pkg::MASK16_ALL;
                end
                qual_pkg::F_ADDR_MASK: begin
                    act_q[acc_act].addr_mask <= reg_wdata_in;
                end
                qual_pkg::F_DATA_V1: begin
                    act_q[acc_act].data_v1   <= reg_wdata_in[7:0];
                    act_q[acc_act].data_mask <= qual_pkg::MASK8_ALL;
                end
                qual_pkg::F_DATA_V2: begin
                    act_q[acc_act].data_v2   <= reg_wdata_in[7:0];
                    act_q[acc_act].data_mask <= qual_pkg::MASK8_ALL;
                end
                qual_pkg::F_DATA_MASK: begin
                    act_q[acc_act].data_mask <= reg_wdata_in[7:0];
                end
                qual_pkg::F_PROBE_V: begin
                    act_q[acc_act].probe_v    <= reg_wdata_in[7:0];
                    act_q[acc_act].probe_mask <= qual_pkg::MASK8_ALL;
                end
                qual_pkg::F_PROBE_MASK: begin
                    act_q[acc_act].probe_mask <= reg_wdata_in[7:0];
                end
                qual_pkg::F_CTRL: begin
                    act_q[acc_act].arange  <= qual_pkg::range_e'(
                        reg_wdata_in[qual_pkg::CTRL_ARANGE +: 2]);
                    act_q[acc_act].drange  <= qual_pkg::range_e'(
                        reg_wdata_in[qual_pkg::CTRL_DRANGE +: 2]);
                    act_q[acc_act].cyc_sel <= qual_pkg::cyc_sel_e'(
                        reg_wdata_in[qual_pkg::CTRL_CYCSEL +: 3]);
                    act_q[acc_act].is_jump <= reg_wdata_in[qual_pkg::CTRL_JUMP];
                    act_q[acc_act].dest    <= reg_wdata_in[qual_pkg::CTRL_DEST +: 2];
                    act_q[acc_act].enable  <= reg_wdata_in[qual_pkg::CTRL_ENABLE];
                end
                default: begin
                    // unmapped field: ignored
                end
            endcase
        end
    end

    // state mode and interrupt mask registers
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_only_q <= qual_pkg::MODE_RESET;
            irq_mask_q  <= '0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == qual_pkg::MODE_ADDR) begin
                addr_only_q <= reg_wdata_in[0];
            end
            if (reg_addr_in == qual_pkg::IRQ_MASK_ADDR) begin
                irq_mask_q <= reg_wdata_in[qual_pkg::NUM_ACT-1:0];
            end
        end
    end

    // sticky status: read clears, a new fire in that cycle wins
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status_q <= '0;
        end else if (reg_rd_in && (reg_addr_in == qual_pkg::STATUS_ADDR)) begin
            status_q <= fire_d;
        end else begin
            status_q <= status_q | fire_d;
        end
    end

    // results and jump request toward the sequencer, lowest action first
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fire_q       <= '0;
            jump_q       <= 1'b0;
            jump_state_q <= 2'b00;
        end else begin
            fire_q       <= fire_d;
            jump_q       <= 1'b0;
            jump_state_q <= jump_state_q;
            for (int i = qual_pkg::NUM_ACT - 1; i >= 0; i--) begin
                if (fire_d[i] && act_q[i].is_jump) begin
                    jump_q       <= 1'b1;
                    jump_state_q <= act_q[i].dest;
                end
            end
        end
    end

    // level interrupt from unmasked sticky flags
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & irq_mask_q);
        end
    end

    // read data, valid in the cycle after the read strobe
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= qual_pkg::RD_ZERO;
        end else if (!reg_rd_in) begin
            rdata_q <= qual_pkg::RD_ZERO;
        end else if (acc_is_act) begin
            unique case (acc_fld)
                qual_pkg::F_ADDR_V1:    rdata_q <= act_q[acc_act].addr_v1;
                qual_pkg::F_ADDR_V2:    rdata_q <= act_q[acc_act].addr_v2;
                qual_pkg::F_ADDR_MASK:  rdata_q <= act_q[acc_act].addr_mask;
                qual_pkg::F_DATA_V1:    rdata_q <= {8'h00, act_q[acc_act].data_v1};
                qual_pkg::F_DATA_V2:    rdata_q <= {8'h00, act_q[acc_act].data_v2};
                qual_pkg::F_DATA_MASK:  rdata_q <= {8'h00, act_q[acc_act].data_mask};
                qual_pkg::F_PROBE_V:    rdata_q <= {8'h00, act_q[acc_act].probe_v};
                qual_pkg::F_PROBE_MASK: rdata_q <= {8'h00, act_q[acc_act].probe_mask};
                qual_pkg::F_CTRL:       rdata_q <= {act_q[acc_act].enable, 5'h00,
                                                    act_q[acc_act].dest,
                                                    act_q[acc_act].is_jump,
                                                    act_q[acc_act].cyc_sel,
                                                    act_q[acc_act].drange,
                                                    act_q[acc_act].arange};
                default:                rdata_q <= qual_pkg::RD_ZERO;
            endcase
        end else begin
            unique case (reg_addr_in)
                qual_pkg::MODE_ADDR:     rdata_q <= {15'h0000, addr_only_q};
                qual_pkg::STATUS_ADDR:   rdata_q <= {12'h000, status_q};
                qual_pkg::IRQ_MASK_ADDR: rdata_q <= {12'h000, irq_mask_q};
                qual_pkg::MATCH_ADDR:    rdata_q <= {12'h000, fire_q};
                default:                 rdata_q <= qual_pkg::RD_ZERO;
            endcase
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_out  = rdata_q;
    assign fire_out       = fire_q;
    assign jump_out       = jump_q;
    assign jump_state_out = jump_state_q;
    assign irq_out        = irq_q;

    // checks on the matching behaviour
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    ignored_fires_a: assert property (
        (bus_evt && act_q[0].enable && act_q[0].addr_mask == 16'h0000
         && act_q[0].data_mask == 8'h00 && act_q[0].probe_mask == 8'h00
         && act_q[0].cyc_sel == qual_pkg::CYC_ALL) |=> fire_q[0])
        else $error("fully ignored action did not fire");
    none_never_a: assert property (
        (act_q[0].cyc_sel == qual_pkg::CYC_NONE) |=> !fire_q[0])
        else $error("action with no cycles fired");
    ad_two_slots_a: assert property (
        $past(!addr_only_q) |-> (fire_q[3:2] == 2'b00))
        else $error("upper action fired in address plus data mode");
    fire_on_cycle_a: assert property (
        (fire_q != '0) |-> $past(bus_evt))
        else $error("fire without an observed bus cycle");
    addr_only_data_a: assert property (
        (bus_evt && addr_only_q && act_q[0].enable && g_act[0].a_ok
         && g_act[0].p_ok && g_act[0].c_ok) |=> fire_q[0])
        else $error("data influenced an address-only action");
    all_conds_a: assert property (
        fire_q[0] |-> $past(g_act[0].a_ok && g_act[0].d_ok && g_act[0].p_ok
                            && g_act[0].c_ok))
        else $error("action fired with an unmet condition");
    value_mask_a: assert property (
        (reg_wr_in && reg_addr_in == 8'h00) |=> (act_q[0].addr_mask == 16'hFFFF))
        else $error("value write did not restore full mask");
    jump_dest_a: assert property (
        (bus_evt && qual[0] && act_q[0].is_jump) |=>
            (jump_q && jump_state_q == $past(act_q[0].dest)))
        else $error("jump destination not presented");
    status_sticky_a: assert property (
        fire_q[0] |-> status_q[0] ##1 (!irq_mask_q[0] || irq_q))
        else $error("fire not latched or not signalled");

    jump_seen_c: cover property (jump_q);
    outside_fire_c: cover property (fire_q[0] && act_q[0].arange == qual_pkg::RANGE_OUTSIDE);
    four_slots_c: cover property (addr_only_q && fire_q[3]);
    irq_seen_c: cover property (irq_q);

endmodule

// ### logic/empty_placeholder.sv
// intentionally empty file

// ### logic/qual_pkg.sv
// shared constants and types of the bus cycle trigger qualifier
package qual_pkg;
    // number of action slots, overall and in address plus data mode
    localparam int          NUM_ACT      = 4;
    localparam int          AD_MAX_ACT   = 2;
    // register map: action fields sit at (action * ACT_STRIDE) + field
    localparam logic [7:0]  ACT_STRIDE   = 8'h10;
    localparam logic [3:0]  F_ADDR_V1    = 4'h0;
    localparam logic [3:0]  F_ADDR_V2    = 4'h1;
    localparam logic [3:0]  F_ADDR_MASK  = 4'h2;
    localparam logic [3:0]  F_DATA_V1    = 4'h3;
    localparam logic [3:0]  F_DATA_V2    = 4'h4;
    localparam logic [3:0]  F_DATA_MASK  = 4'h5;
    localparam logic [3:0]  F_PROBE_V    = 4'h6;
    localparam logic [3:0]  F_PROBE_MASK = 4'h7;
    localparam logic [3:0]  F_CTRL       = 4'h8;
    // global registers
    localparam logic [7:0]  MODE_ADDR    = 8'h40;
    localparam logic [7:0]  STATUS_ADDR  = 8'h41;
    localparam logic [7:0]  IRQ_MASK_ADDR = 8'h42;
    localparam logic [7:0]  MATCH_ADDR   = 8'h43;
    // control word field positions
    localparam int          CTRL_ARANGE  = 0;
    localparam int          CTRL_DRANGE  = 2;
    localparam int          CTRL_CYCSEL  = 4;
    localparam int          CTRL_JUMP    = 7;
    localparam int          CTRL_DEST    = 8;
    localparam int          CTRL_ENABLE  = 15;
    // values after reset and after a value write
    localparam logic [15:0] MASK16_IGNORE = 16'h0000;
    localparam logic [7:0]  MASK8_IGNORE  = 8'h00;
    localparam logic [15:0] MASK16_ALL    = 16'hFFFF;
    localparam logic [7:0]  MASK8_ALL     = 8'hFF;
    localparam logic [15:0] RD_ZERO       = 16'h0000;
    localparam logic        MODE_RESET    = 1'b0;

    // range interpretation of a value pair
    typedef enum logic [1:0] {
        RANGE_SINGLE,
        RANGE_EITHER,
        RANGE_INSIDE,
        RANGE_OUTSIDE
    } range_e;

    // cycle type selection
    typedef enum logic [2:0] {
        CYC_ALL,
        CYC_NONE,
        CYC_READ,
        CYC_WRITE,
        CYC_READ_WRITE,
        CYC_FETCH,
        CYC_FETCH_READ,
        CYC_FETCH_WRITE
    } cyc_sel_e;

    // one action's programmed qualifiers
    typedef struct packed {
        logic        enable;
        logic        is_jump;
        logic [1:0]  dest;
        cyc_sel_e    cyc_sel;
        range_e      drange;
        range_e      arange;
        logic [15:0] addr_v1;
        logic [15:0] addr_v2;
        logic [15:0] addr_mask;
        logic [7:0]  data_v1;
        logic [7:0]  data_v2;
        logic [7:0]  data_mask;
        logic [7:0]  probe_v;
        logic [7:0]  probe_mask;
    } act_cfg_s;

    // one observed target bus sample
    typedef struct packed {
        logic        strobe;
        logic        instruction_fetch_cycle;
        logic        memory_read_cycle;
        logic        memory_write_cycle;
        logic [15:0] addr;
        logic [7:0]  data;
        logic [7:0]  probe;
    } bus_obs_s;
endpackage

// ### testbench/target_bus_model.sv
// target bus model: one bus cycle per request, released lines scrambled
module target_bus_model (
    // clock
    input  wire logic          mclk_in,
    // request from the bench
    input  wire logic          go_in,
    input  wire logic [2:0]    kind_in,
    input  wire logic [15:0]   addr_in,
    input  wire logic [7:0]    data_in,
    input  wire logic [7:0]    probe_in,
    // target bus toward the block
    output qual_pkg::bus_obs_s bus_out,
    output logic               busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q = 4'h0; // phase of the current cycle, zero when idle
    initial bus_out = '0;
    // fields settle three clocks before strobe rises and hold four after it falls
    always @(posedge mclk_in) begin
        if (go_in) begin
            cnt_q <= 4'hA;
            bus_out <= {1'b0, kind_in, addr_in, data_in, probe_in};
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            bus_out.strobe <= (cnt_q <= 4'h8) && (cnt_q >= 4'h5);
        end else begin
            // released bus zeroes strobe and kind, inverts address, data and probe each clock, so their stale values return on alternate clocks
            bus_out <= {4'h0, ~bus_out.addr, ~bus_out.data, ~bus_out.probe};
        end
    end
    assign busy_out = (cnt_q != 4'h0);
endmodule

// ### testbench/testbench.sv
// self-checking bench for the bus cycle trigger qualifier
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // design side signals
    logic               mclk_in = 1'b0;
    logic               nrst_in = 1'b0;
    logic [7:0]         reg_addr_in = 8'h00;
    logic [15:0]        reg_wdata_in = 16'h0000;
    logic               reg_wr_in = 1'b0;
    logic               reg_rd_in = 1'b0;
    logic [15:0]        reg_rdata_out;
    qual_pkg::bus_obs_s bus_in;
    logic [3:0]         fire_out;
    logic               jump_out;
    logic [1:0]         jump_state_out;
    logic               irq_out;
    // bus model request and bench state
    logic               go = 1'b0;
    logic [2:0]         kind = 3'b010;
    logic [15:0]        addr = 16'h0000;
    logic [7:0]         data = 8'h00;
    logic [7:0]         probe = 8'h00;
    logic               busy;
    logic [3:0]         f;
    logic               jseen;
    logic [15:0]        rv;
    int                 fail_count = 0;
    int                 checked = 0;
    int                 i;
    int                 j;
    // range table: two probes per interpretation, first qualifies
    localparam logic [15:0] RA [8] = '{16'h1000, 16'h2000, 16'h2000, 16'h1500,
                                       16'h1000, 16'h2001, 16'h0FFF, 16'h1000};
    localparam logic [7:0]  RE = 8'h55;
    // cycle table: per selection bits fetch, read, write
    localparam logic [23:0] CT = 24'b101_110_100_011_001_010_000_111;

    bus_cycle_trigger_qualifier bus_cycle_trigger_qualifier_inst (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .bus_in(bus_in), .fire_out(fire_out),
        .jump_out(jump_out), .jump_state_out(jump_state_out), .irq_out(irq_out));
    target_bus_model target_bus_model_inst (
        .mclk_in(mclk_in), .go_in(go), .kind_in(kind), .addr_in(addr), .data_in(data),
        .probe_in(probe), .bus_out(bus_in), .busy_out(busy));

    // 10 MHz clock
    initial begin
        forever #50 mclk_in = ~mclk_in;
    end
    // closing report
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one register write cycle
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    // one register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(negedge mclk_in);
        v = reg_rdata_out;
    endtask
    // one target bus cycle, collecting every fire and jump pulse
    task automatic cyc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d,
                       input logic [7:0] p);
        @(posedge mclk_in);
        kind <= k;
        addr <= a;
        data <= d;
        probe <= p;
        go <= 1'b1;
        @(posedge mclk_in);
        go <= 1'b0;
        f = 4'h0;
        jseen = 1'b0;
        repeat (16) begin
            @(negedge mclk_in);
            f = f | fire_out;
            jseen = jseen | jump_out;
        end
        if (busy !== 1'b0) begin
            fail_count++;
            summarize();
        end
    endtask
    // hang guard
    initial begin
        repeat (60000) @(posedge mclk_in);
        fail_count++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge mclk_in);
        nrst_in <= 1'b1;
        rd(8'h02, rv); `CHK(rv, qual_pkg::MASK16_IGNORE)
        rd(8'h08, rv); `CHK(rv, 16'h0000)
        rd(8'h3F, rv); `CHK(rv, 16'h0000)
        cyc(3'b100, 16'h1234, 8'h00, 8'h00); `CHK(f, 4'h0)
        wr(8'h08, 16'h8000);
        cyc(3'b001, 16'hBEEF, 8'h77, 8'h33); `CHK(f, 4'h1)
        $display("test defaults done");
        wr(8'h00, 16'h1000);
        rd(8'h02, rv); `CHK(rv, qual_pkg::MASK16_ALL)
        wr(8'h01, 16'h2000);
        for (i = 0; i < 8; i++) begin
            wr(8'h08, 16'h8000 | 16'(i / 2));
            cyc(3'b010, RA[i], 8'h00, 8'h00); `CHK(f[0], RE[i])
        end
        wr(8'h08, 16'h8000);
        wr(8'h02, 16'hFF00);
        cyc(3'b010, 16'h10AB, 8'h00, 8'h00); `CHK(f[0], 1'b1)
        cyc(3'b010, 16'h11AB, 8'h00, 8'h00); `CHK(f[0], 1'b0)
        $display("test address done");
        wr(8'h03, 16'h005A);
        cyc(3'b010, 16'h1000, 8'h5A, 8'h00); `CHK(f[0], 1'b1)
        cyc(3'b010, 16'h1000, 8'h5B, 8'h00); `CHK(f[0], 1'b0)
        wr(8'h40, 16'h0001);
        cyc(3'b010, 16'h1000, 8'h5B, 8'h00); `CHK(f[0], 1'b1)
        wr(8'h40, 16'h0000);
        wr(8'h04, 16'h005B);
        wr(8'h08, 16'h8004);
        cyc(3'b010, 16'h1000, 8'h5B, 8'h00); `CHK(f[0], 1'b1)
        $display("test data done");
        wr(8'h02, 16'h0000);
        wr(8'h05, 16'h0000);
        for (i = 0; i < 8; i++) begin
            wr(8'h08, 16'h8000 | 16'(i << 4));
            for (j = 0; j < 3; j++) begin
                cyc(3'b100 >> j, 16'h4321, 8'hC3, 8'h00);
                `CHK(f[0], CT[i * 3 + 2 - j])
            end
        end
        wr(8'h08, 16'h800F);
        cyc(3'b010, 16'h4321, 8'hC3, 8'h00); `CHK(f[0], 1'b1)
        $display("test cycles done");
        wr(8'h06, 16'h000A);
        wr(8'h07, 16'h000F);
        wr(8'h08, 16'h8380);
        cyc(3'b010, 16'h0000, 8'h00, 8'hFB); `CHK(f[0], 1'b0)
        cyc(3'b010, 16'h0000, 8'h00, 8'hFA); `CHK(f[0], 1'b1)
        `CHK(jseen, 1'b1)
        `CHK(jump_state_out, 2'h3)
        $display("test probe_jump done");
        rd(8'h41, rv);
        wr(8'h42, 16'h0001);
        cyc(3'b010, 16'h0000, 8'h00, 8'hFA); `CHK(irq_out, 1'b1)
        rd(8'h41, rv); `CHK(rv, 16'h0001)
        repeat (2) @(negedge mclk_in);
        `CHK(irq_out, 1'b0)
        wr(8'h42, 16'h0000);
        cyc(3'b010, 16'h0000, 8'h00, 8'hFA); `CHK(irq_out, 1'b0)
        rd(8'h41, rv); `CHK(rv, 16'h0001)
        $display("test interrupt done");
        wr(8'h28, 16'h8000);
        cyc(3'b001, 16'h0000, 8'h00, 8'h00); `CHK(f & 4'h4, 4'h0)
        wr(8'h40, 16'h0001);
        cyc(3'b001, 16'h0000, 8'h00, 8'h00); `CHK(f & 4'h4, 4'h4)
        $display("test action_count done");
        summarize();
    end
endmodule
